/* File: dv/bus_master_ctrl_bench.sv */
// Self-checking bench for the bus master controller
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("mismatch %0t %h %h", $time, a, e); end end
module bus_master_ctrl_bench;
  logic ref_clk_in = 1'b0, reset_in = 1'b1, req_valid_in = 1'b0, svc_ok = 1'b1, perr = 1'b0;
  logic busy = 1'b0;
  logic req_ready_out, rsp_valid_out, aborted_out, dma_level_request_out, dma_level_grant_in;
  logic dma_level_grant_out, addr_oe_out, data_oe_out, write_out, byte_out, ok;
  logic initiator_strobe_out, target_reply_strobe_in, parity_error_in;
  logic [2:0]  shut = 3'h0;
  logic [3:0]  req_level_in = 4'h0, dly = 4'h0;
  logic [3:0]  irq_level_request_out, irq_level_grant_in, irq_level_grant_out;
  logic [4:0]  grant;
  logic [15:0] data_out, sd, bus_d;
  logic [17:0] addr_out;
  bus_master_pkg::req_s req_in = '0;
  bus_master_pkg::rsp_s rsp_out, rsp;
  int fail_count = 0;
  int cmp_count = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  // Shared data lines: the master drives them only on writes
  assign bus_d = data_oe_out ? data_out : sd;
  assign {dma_level_grant_in, irq_level_grant_in} = grant;
  bus_master_ctrl DUT (.ref_clk_in, .reset_in, .req_valid_in, .req_in, .req_level_in,
    .req_ready_out, .rsp_valid_out, .rsp_out, .aborted_out, .irq_level_grant_in,
    .dma_level_grant_in, .irq_level_request_out, .dma_level_request_out, .irq_level_grant_out,
    .dma_level_grant_out, .addr_out, .addr_oe_out, .data_out, .data_oe_out, .data_in(bus_d),
    .write_out, .byte_out, .initiator_strobe_out, .target_reply_strobe_in, .parity_error_in,
    .busy_in(busy), .system_reset_line_in(shut[0]), .power_fail_warning_in(shut[1]),
    .power_down_line_in(shut[2]));
  bus_slave_model slave (.ref_clk_in, .addr_in(addr_out), .data_in(bus_d), .write_in(write_out),
    .byte_in(byte_out), .strobe_in(initiator_strobe_out), .delay_in(dly), .perr_in(perr),
    .data_out(sd), .reply_out(target_reply_strobe_in), .parity_error_out(parity_error_in),
    .request_in({dma_level_request_out, irq_level_request_out}), .svc_cpu_ok_in(svc_ok),
    .grant_out(grant));
  // Request is raised only while ready shows high, so the next edge takes it
  task automatic issue(input bus_master_pkg::op_e op, input logic [17:0] a,
                       input logic [15:0] d, input logic [3:0] lv);
    int n = 0;
    @(negedge ref_clk_in);
    while (req_ready_out !== 1'b1 && n < 400) begin
      @(negedge ref_clk_in);
      n++;
    end
    req_in = '{op, a, d};
    req_level_in = lv;
    req_valid_in = 1'b1;
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
  endtask : issue
  task automatic wait_rsp(input int lim);
    int n = 0;
    ok = 1'b0;
    while (!ok && n < lim) begin
      @(negedge ref_clk_in);
      n++;
      ok = (rsp_valid_out === 1'b1);
    end
    rsp = rsp_out;
  endtask : wait_rsp
  task automatic xfer(input bus_master_pkg::op_e op, input logic [17:0] a,
                      input logic [15:0] d, input logic [3:0] lv);
    issue(op, a, d, lv);
    wait_rsp(400);
    `CHK(ok, 1'b1)
  endtask : xfer
  // Memory byte merge and lane pick, fast then slow slave
  task automatic sc_mem;
    xfer(bus_master_pkg::OP_WRITE_WORD, 18'h0_0010, 16'h1234, 4'h0);
    // Odd byte sits in its own lane only, so a wrong lane pick writes zero
    xfer(bus_master_pkg::OP_WRITE_BYTE, 18'h0_0011, 16'hAB00, 4'h0);
    dly = 4'h9;
    xfer(bus_master_pkg::OP_READ, 18'h0_0011, 16'h0000, 4'h0);
    `CHK(rsp.rdata, 16'hAB34)
    `CHK(rsp.rbyte, 8'hAB)
    `CHK(rsp.io_space, 1'b0)
    xfer(bus_master_pkg::OP_READ, 18'h0_0010, 16'h0000, 4'h0);
    `CHK(rsp.rbyte, 8'h34)
  endtask : sc_mem
  // I/O register takes the whole word on a byte write
  task automatic sc_io;
    dly = 4'h2;
    xfer(bus_master_pkg::OP_WRITE_WORD, 18'h3_E002, 16'h5678, 4'h0);
    xfer(bus_master_pkg::OP_WRITE_BYTE, 18'h3_E003, 16'h9A9A, 4'h0);
    xfer(bus_master_pkg::OP_READ, 18'h3_E002, 16'h0000, 4'h0);
    `CHK(rsp.rdata, 16'h9A9A)
    `CHK(rsp.io_space, 1'b1)
  endtask : sc_io
  // Bus still busy with another owner: grant is won early, driving waits
  task automatic sc_busy;
    busy = 1'b1;
    issue(bus_master_pkg::OP_WRITE_WORD, 18'h0_0014, 16'hC3C3, 4'h0);
    repeat (12) @(negedge ref_clk_in);
    `CHK(dma_level_grant_in, 1'b1)
    `CHK(addr_oe_out, 1'b0)
    `CHK(dma_level_grant_out, 1'b0)
    busy = 1'b0;
    wait_rsp(400);
    `CHK(ok, 1'b1)
    xfer(bus_master_pkg::OP_READ, 18'h0_0014, 16'h0000, 4'h0);
    `CHK(rsp.rdata, 16'hC3C3)
  endtask : sc_busy
  // Refused interrupt levels wait, then each shutdown line cancels
  task automatic sc_shut;
    int n;
    svc_ok = 1'b0;
    for (int i = 0; i < 3; i++) begin
      issue(bus_master_pkg::OP_READ, 18'h0_0010, 16'h0000, 4'h1 << i);
      wait_rsp(40);
      `CHK(ok, 1'b0)
      `CHK(irq_level_request_out, 4'h1 << i)
      shut[i] = 1'b1;
      n = 0;
      while (aborted_out !== 1'b1 && n < 50) begin
        @(negedge ref_clk_in);
        n++;
      end
      `CHK(aborted_out, 1'b1)
      // Ready must stay refused for as long as the shutdown line is held
      repeat (6) @(negedge ref_clk_in);
      `CHK(req_ready_out, 1'b0)
      shut = 3'h0;
    end
    // Dma level still granted with interrupts refused
    xfer(bus_master_pkg::OP_READ, 18'h0_0010, 16'h0000, 4'h0);
    `CHK(rsp.rdata, 16'hAB34)
  endtask : sc_shut
  // Permitted top interrupt level with a slave parity report
  task automatic sc_irq;
    svc_ok = 1'b1;
    perr = 1'b1;
    xfer(bus_master_pkg::OP_READ, 18'h0_0010, 16'h0000, 4'h8);
    `CHK(rsp.rdata, 16'hAB34)
    `CHK(rsp.parity_err, 1'b1)
    perr = 1'b0;
  endtask : sc_irq
  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(negedge ref_clk_in);
    reset_in = 1'b0;
    sc_mem();
    sc_io();
    sc_busy();
    sc_shut();
    sc_irq();
    complete_run();
  end
  // Whole run needs a few hundred cycles; this cuts a hang short
  initial begin
    #2_000_000;
    fail_count++;
    complete_run();
  end
endmodule : bus_master_ctrl_bench

/* File: dv/bus_master_ctrl_checker.sv */
// Assertion checker for the bus master controller ports
`timescale 1ns/1ps
module bus_master_ctrl_checker (
  // Watched ports
  input wire logic        ref_clk_in,
  input wire logic        reset_in,
  input wire logic        rsp_valid_out,
  input wire logic        aborted_out,
  input wire logic        req_ready_out,
  input wire logic        dma_level_request_out,
  input wire logic        dma_level_grant_out,
  input wire logic [17:0] addr_out,
  input wire logic        addr_oe_out,
  input wire logic [15:0] data_out,
  input wire logic        data_oe_out,
  input wire logic        write_out,
  input wire logic        byte_out,
  input wire logic        initiator_strobe_out,
  input wire logic        power_down_line_in
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Strobe only rises over an address that is already driven and settled
  property p_setup; $rose(initiator_strobe_out) |-> $past(addr_oe_out) && $stable(addr_out); endproperty
  a_setup: assert property (p_setup) else $error("strobe before address");
  property p_hold; initiator_strobe_out && $past(initiator_strobe_out) |-> $stable(addr_out) && $stable(data_out); endproperty
  a_hold: assert property (p_hold) else $error("bus moved under strobe");
  property p_rd0; addr_oe_out && !write_out |-> !addr_out[0]; endproperty
  a_rd0: assert property (p_rd0) else $error("odd read address");
  property p_word0; addr_oe_out && write_out && !byte_out |-> !addr_out[0]; endproperty
  a_word0: assert property (p_word0) else $error("odd word address");
  property p_lanes; data_oe_out && byte_out |-> data_out[15:8] == data_out[7:0]; endproperty
  a_lanes: assert property (p_lanes) else $error("byte lanes differ");
  // A device that wants the bus must block the grant it receives
  property p_fwd; dma_level_request_out [*4] |-> !dma_level_grant_out; endproperty
  a_fwd: assert property (p_fwd) else $error("grant passed while requesting");
  // A grant just won must not leak downstream while its synchronised copy drains
  property p_won; $fell(dma_level_request_out) |-> (!dma_level_grant_out) [*3]; endproperty
  a_won: assert property (p_won) else $error("won grant passed on");
  property p_abort; power_down_line_in [*5] |-> !req_ready_out && !initiator_strobe_out; endproperty
  a_abort: assert property (p_abort) else $error("active during shutdown");
  property p_rsp; rsp_valid_out |-> $past(initiator_strobe_out) ##1 !rsp_valid_out; endproperty
  a_rsp: assert property (p_rsp) else $error("answer without strobe");
  c_read: cover property (initiator_strobe_out && !write_out);
  c_byte: cover property (initiator_strobe_out && byte_out);
  c_abort: cover property (aborted_out);
endmodule : bus_master_ctrl_checker

bind bus_master_ctrl bus_master_ctrl_checker chk (.ref_clk_in, .reset_in, .rsp_valid_out,
  .aborted_out, .req_ready_out, .dma_level_request_out, .dma_level_grant_out, .addr_out,
  .addr_oe_out, .data_out, .data_oe_out, .write_out, .byte_out, .initiator_strobe_out,
  .power_down_line_in);

/* File: dv/bus_slave_model.sv */
// Behavioural slave memory and central arbitrator on the far side
`timescale 1ns/1ps
module bus_slave_model (
  // Clock
  input  wire logic        ref_clk_in,
  // Transfer side
  input  wire logic [17:0] addr_in,
  input  wire logic [15:0] data_in,
  input  wire logic        write_in,
  input  wire logic        byte_in,
  input  wire logic        strobe_in,
  input  wire logic [3:0]  delay_in,
  input  wire logic        perr_in,
  output logic      [15:0] data_out = 16'h0000,
  output logic             reply_out = 1'b0,
  output logic             parity_error_out = 1'b0,
  // Arbitration side: {dma, irq7..irq4}
  input  wire logic [4:0]  request_in,
  input  wire logic        svc_cpu_ok_in,
  output logic      [4:0]  grant_out
);
  logic [15:0] mem [0:15];
  logic [15:0] w;
  logic [3:0]  cnt = 4'h0;
  // Grants follow requests at once, so selection overlaps any transfer
  always_comb begin
    grant_out = 5'h00;
    if (request_in[4]) grant_out[4] = 1'b1;
    else if (svc_cpu_ok_in) begin
      for (int i = 3; i >= 0; i--) if (request_in[i] && grant_out[3:0] == 4'h0) grant_out[i] = 1'b1;
    end
  end
  // Slave answers after a chosen delay; data lines toggle while strobe is low; while it is high they hold, except that a read loads its word with the reply
  always @(posedge ref_clk_in) begin
    w = mem[addr_in[4:1]];
    if (!strobe_in) begin
      reply_out <= 1'b0;
      cnt <= 4'h0;
      parity_error_out <= 1'b0;
      data_out <= ~data_out;
    end else if (!reply_out && cnt < delay_in) cnt <= cnt + 4'h1;
    else if (!reply_out) begin
      if (!write_in) data_out <= w;
      else if (!byte_in || addr_in >= bus_master_pkg::IO_BASE) mem[addr_in[4:1]] <= data_in;
      else if (addr_in[0]) mem[addr_in[4:1]] <= {data_in[15:8], w[7:0]};
      else mem[addr_in[4:1]] <= {w[15:8], data_in[7:0]};
      parity_error_out <= perr_in;
      reply_out <= 1'b1;
    end
  end
endmodule : bus_slave_model

/* File: hdl/bus_master_ctrl.sv */
// Clocked bus master: issues strobed word/byte transfers and takes grants
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: Arbiter picks next owner while current owner still transfers; we request early.
// RULE2: Address is driven first, initiator strobe follows after a setup count.
// RULE3: Slave returns read word with reply strobe acting as data strobe and ack.
// RULE4: No timeout; the master waits for the reply strobe indefinitely.
// RULE5: Addresses are 18 bits, one byte each, bit 0 least significant.
// RULE6: Top 8K byte addresses are I/O registers, the lower 248K memory.
// RULE7: Slave reports its internal parity errors on a dedicated line.
// RULE8: No parity is generated or checked on any bus line here.
// RULE9: Reset line, power warning and power down are monitored; we abort on them.
// RULE10: Arbiter grants dma level itself without processor involvement.
// RULE11: Arbiter asks the interrupt service processor before an irq grant.
// RULE12: One processor on the bus services all interrupts.
// RULE13: Word accesses put address bit 0 at zero.
// RULE14: Data words are 16 bits, bit 0 least significant.
// RULE15: Even bytes on bits 7..0, odd bytes on bits 15..8, never justified.
// RULE16: Reads return a whole word; master picks the lane by address bit 0.
// RULE17: Address bit 0 is never asserted on the bus during reads.
// RULE18: On byte write the slave updates only the selected byte.
// RULE19: Byte write drives data on both lanes and asserts address bit 0 correctly.
// RULE20: Word-only slave locations take the whole word on a byte write.
// RULE21: Five request levels, dma highest then irq 7 down to 4.
// RULE22: Grant passes along the chain unless this device wants the bus.
// RULE23: Incoming strobes are synchronised; address and data held while strobing.
module bus_master_ctrl (
  // Clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      reset_in,
  // User request side
  input  wire logic                      req_valid_in,
  input  wire bus_master_pkg::req_s      req_in,
  input  wire logic [3:0]                req_level_in,
  output logic                           req_ready_out,
  output logic                           rsp_valid_out,
  output bus_master_pkg::rsp_s           rsp_out,
  output logic                           aborted_out,
  // Arbitration chain
  input  wire logic [3:0]                irq_level_grant_in,
  input  wire logic                      dma_level_grant_in,
  output logic [3:0]                     irq_level_request_out,
  output logic                           dma_level_request_out,
  output logic [3:0]                     irq_level_grant_out,
  output logic                           dma_level_grant_out,
  // Data transfer bus, open drain style: value, enable, and sampled input
  output logic [17:0]                    addr_out,
  output logic                           addr_oe_out,
  output logic [15:0]                    data_out,
  output logic                           data_oe_out,
  input  wire logic [15:0]               data_in,
  output logic                           write_out,
  output logic                           byte_out,
  output logic                           initiator_strobe_out,
  input  wire logic                      target_reply_strobe_in,
  input  wire logic                      parity_error_in,
  input  wire logic                      busy_in,
  // Initialization and shutdown lines
  input  wire logic                      system_reset_line_in,
  input  wire logic                      power_fail_warning_in,
  input  wire logic                      power_down_line_in
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARB,
    ST_WAIT_FREE,
    ST_SETUP,
    ST_STROBE,
    ST_RELEASE
  } state_e;

  // Synchronisers for every asynchronous control pin; stage 0 feeds stage 1 only
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] s0_r;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] raw;
  assign raw = {target_reply_strobe_in, parity_error_in, busy_in, system_reset_line_in,
                power_fail_warning_in, power_down_line_in, dma_level_grant_in,
                irq_level_grant_in};
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s0_r <= '0;
      s1_r <= '0;
    end else begin
      s0_r <= raw; // RULE23
      s1_r <= s0_r;
    end
  end

  logic       reply_s;
  logic       perr_s;
  logic       busy_s;
  logic       shutdown_s;
  logic       dma_g_s;
  logic [3:0] irq_g_s;
  assign reply_s    = s1_r[10];
  assign perr_s     = s1_r[9];
  assign busy_s     = s1_r[8];
  assign shutdown_s = s1_r[7] | s1_r[6] | s1_r[5]; // RULE9
  assign dma_g_s    = s1_r[4];
  assign irq_g_s    = s1_r[3:0];

  // Data bus sampled every cycle through two stages in step with reply; slave holds it while replying
  logic [15:0] din_s0_r;
  logic [15:0] din_s1_r;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      din_s0_r <= 16'h0000;
      din_s1_r <= 16'h0000;
    end else begin
      din_s0_r <= data_in;
      din_s1_r <= din_s0_r;
    end
  end

  state_e                 state_r, state_nxt;
  bus_master_pkg::req_s   cur_r, cur_nxt;
  logic [4:0]             lvl_r, lvl_nxt;
  logic [3:0]             cnt_r, cnt_nxt;
  logic                   rdy_r, rdy_nxt;
  logic                   rv_r, rv_nxt;
  bus_master_pkg::rsp_s   rsp_r, rsp_nxt;
  logic                   ab_r, ab_nxt;
  logic [17:0]            a_r, a_nxt;
  logic                   aoe_r, aoe_nxt;
  logic [15:0]            d_r, d_nxt;
  logic                   doe_r, doe_nxt;
  logic                   wr_r, wr_nxt;
  logic                   by_r, by_nxt;
  logic                   ms_r, ms_nxt;
  logic [4:0]             gout_r, gout_nxt, blk_r, blk_nxt;
  logic                   won;

  // Requested levels that have their grant in; any one of them wins the chain here
  assign won = |(lvl_r & {dma_g_s, irq_g_s});

  // Next-state logic for the master sequence
  always_comb begin
    state_nxt = state_r;
    cur_nxt   = cur_r;
    lvl_nxt   = lvl_r;
    cnt_nxt   = cnt_r;
    rdy_nxt   = 1'b0;
    rv_nxt    = 1'b0;
    rsp_nxt   = rsp_r;
    ab_nxt    = 1'b0;
    a_nxt     = a_r;
    aoe_nxt   = aoe_r;
    d_nxt     = d_r;
    doe_nxt   = doe_r;
    wr_nxt    = wr_r;
    by_nxt    = by_r;
    ms_nxt    = ms_r;
    // Grants not wanted pass on; a won one stays blocked until its synced copy drops
    blk_nxt   = lvl_r | (blk_r & {dma_g_s, irq_g_s});
    gout_nxt  = {dma_g_s, irq_g_s} & ~(lvl_r | blk_r); // RULE22
    unique case (state_r)
      ST_IDLE: begin
        rdy_nxt = !shutdown_s;
        if (req_valid_in && rdy_r && !shutdown_s) begin
          cur_nxt   = req_in;
          rdy_nxt   = 1'b0;
          // Request raised at once so arbitration overlaps a running transfer
          lvl_nxt   = (req_level_in == 4'h0) ? 5'h10 : {1'b0, req_level_in}; // RULE1 RULE21
          state_nxt = ST_ARB;
        end
      end
      ST_ARB: begin
        if (won) begin
          state_nxt = ST_WAIT_FREE; // RULE22
        end
      end
      ST_WAIT_FREE: begin
        // Wait for the previous owner to finish before driving
        if (!busy_s && !reply_s) begin
          lvl_nxt = 5'h00;
          a_nxt   = cur_r.addr;
          if (cur_r.op != bus_master_pkg::OP_WRITE_BYTE) begin
            a_nxt[0] = 1'b0; // RULE13 RULE17
          end
          d_nxt     = cur_r.wdata;
          if (cur_r.op == bus_master_pkg::OP_WRITE_BYTE) begin
            // Same byte on both lanes; slave picks by address bit 0
            d_nxt = cur_r.addr[0] ? {cur_r.wdata[15:8], cur_r.wdata[15:8]}
                                  : {cur_r.wdata[7:0], cur_r.wdata[7:0]}; // RULE15 RULE19
          end
          aoe_nxt   = 1'b1;
          doe_nxt   = (cur_r.op != bus_master_pkg::OP_READ);
          wr_nxt    = (cur_r.op != bus_master_pkg::OP_READ);
          by_nxt    = (cur_r.op == bus_master_pkg::OP_WRITE_BYTE);
          cnt_nxt   = bus_master_pkg::SETUP_CYC;
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          ms_nxt    = 1'b1; // RULE2
          state_nxt = ST_STROBE;
        end
      end
      ST_STROBE: begin
        // Wait as long as the slave needs; address and data are held
        if (reply_s) begin // RULE4 RULE3
          ms_nxt           = 1'b0;
          rsp_nxt.rdata    = din_s1_r; // RULE14
          rsp_nxt.rbyte    = cur_r.addr[0] ? din_s1_r[15:8] : din_s1_r[7:0]; // RULE16
          rsp_nxt.parity_err = perr_s; // RULE7 RULE8
          rsp_nxt.io_space = (cur_r.addr >= bus_master_pkg::IO_BASE); // RULE5 RULE6
          rv_nxt           = 1'b1;
          state_nxt        = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // Hold lines until the slave drops its reply
        if (!reply_s) begin
          aoe_nxt   = 1'b0;
          doe_nxt   = 1'b0;
          wr_nxt    = 1'b0;
          by_nxt    = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
    endcase
    // Shutdown lines abort whatever is running and release the bus
    if (shutdown_s && state_r != ST_IDLE) begin // RULE9
      state_nxt = ST_IDLE;
      lvl_nxt   = 5'h00;
      aoe_nxt   = 1'b0;
      doe_nxt   = 1'b0;
      wr_nxt    = 1'b0;
      by_nxt    = 1'b0;
      ms_nxt    = 1'b0;
      rv_nxt    = 1'b0;
      ab_nxt    = 1'b1;
    end
  end

  // Registers of the master sequence
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_r <= ST_IDLE;
      cur_r   <= '0;
      lvl_r   <= 5'h00;
      cnt_r   <= 4'h0;
      rdy_r   <= 1'b0;
      rv_r    <= 1'b0;
      rsp_r   <= '0;
      ab_r    <= 1'b0;
      a_r     <= 18'h0_0000;
      aoe_r   <= 1'b0;
      d_r     <= 16'h0000;
      doe_r   <= 1'b0;
      wr_r    <= 1'b0;
      by_r    <= 1'b0;
      ms_r    <= 1'b0;
      gout_r  <= 5'h00;
      blk_r   <= 5'h00;
    end else begin
      state_r <= state_nxt;
      cur_r   <= cur_nxt;
      lvl_r   <= lvl_nxt;
      cnt_r   <= cnt_nxt;
      rdy_r   <= rdy_nxt;
      rv_r    <= rv_nxt;
      rsp_r   <= rsp_nxt;
      ab_r    <= ab_nxt;
      a_r     <= a_nxt;
      aoe_r   <= aoe_nxt;
      d_r     <= d_nxt;
      doe_r   <= doe_nxt;
      wr_r    <= wr_nxt;
      by_r    <= by_nxt;
      ms_r    <= ms_nxt;
      gout_r  <= gout_nxt;
      blk_r   <= blk_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign req_ready_out         = rdy_r;
  assign rsp_valid_out         = rv_r;
  assign rsp_out               = rsp_r;
  assign aborted_out           = ab_r;
  assign dma_level_request_out = lvl_r[4];
  assign irq_level_request_out = lvl_r[3:0];
  assign dma_level_grant_out   = gout_r[4];
  assign irq_level_grant_out   = gout_r[3:0];
  assign addr_out              = a_r;
  assign addr_oe_out           = aoe_r;
  assign data_out              = d_r;
  assign data_oe_out           = doe_r;
  assign write_out             = wr_r;
  assign byte_out              = by_r;
  assign initiator_strobe_out  = ms_r;

endmodule : bus_master_ctrl

/* File: hdl/bus_master_pkg.sv */
// Package with constants and carrier types for the backplane bus master controller
package bus_master_pkg;
  localparam int ADDR_W        = 18;
  localparam int DATA_W        = 16;
  localparam int BYTE_W        = 8;
  localparam int LEVELS        = 5;
  localparam int LVL_DMA       = 4;    // Index of dma level; 3..0 are irq levels 7..4
  localparam int SYNC_STAGES   = 2;
  // I/O page: top 8K of the 256K byte space
  localparam logic [17:0] IO_BASE = 18'h3_E000;
  // Least setup time of address before strobe, in ns, and derived cycles
  localparam int SETUP_NS      = 150;
  localparam int CLK_NS        = 50;
  localparam int SETUP_CYC_RAW = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SETUP_CYC = 4'(SETUP_CYC_RAW < 1 ? 1 : SETUP_CYC_RAW);

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE_WORD,
    OP_WRITE_BYTE
  } op_e;

  // Request from the user side
  typedef struct packed {
    op_e         op;
    logic [17:0] addr;
    logic [15:0] wdata;
  } req_s;

  // Answer to the user side
  typedef struct packed {
    logic [15:0] rdata;
    logic [7:0]  rbyte;
    logic        parity_err;
    logic        io_space;
  } rsp_s;
endpackage : bus_master_pkg
